// file: adcreg_pkg.sv
/*
 * Package for the A/D converter control block: register indices, field
 * positions, reset values, conversion timing and input-source decodes.
 * Assumes a 50 MHz system clock and an Avalon-MM register slave.
 */
`default_nettype none
package adcreg_pkg;
   // Register byte addresses (one 32-bit word each)
   localparam logic [4:0] ADDR_RESULT_HIGH = 5'h00;
   localparam logic [4:0] ADDR_RESULT_LOW  = 5'h04;
   localparam logic [4:0] ADDR_START_FMT   = 5'h08;
   localparam logic [4:0] ADDR_SRC_CLK     = 5'h0C;
   localparam logic [4:0] ADDR_REF_GAIN    = 5'h10;
   localparam logic [4:0] ADDR_BANDGAP     = 5'h14;

   // Start/format/channel register fields
   localparam int BIT_START   = 7;
   localparam int BIT_BUSY    = 6;
   localparam int BIT_ENABLE  = 5;
   localparam int BIT_FORMAT  = 4;
   localparam int CH_MSB      = 3;
   // Source/clock register fields
   localparam int SRC_MSB     = 7;
   localparam int SRC_LSB     = 4;
   localparam int DIV_MSB     = 2;
   // Reference/gain register fields
   localparam int BIT_AMP_EN  = 7;
   localparam int BIT_AMP_IN  = 4;
   localparam int REF_MSB     = 3;
   localparam int REF_LSB     = 2;
   localparam int GAIN_MSB    = 1;
   // Bandgap register field
   localparam int BIT_BG_EN   = 0;

   // Writable masks; other bits are unimplemented and read zero, except the start/format busy bit, which reads status
   localparam logic [7:0] MASK_START_FMT = 8'hBF;
   localparam logic [7:0] MASK_SRC_CLK   = 8'hF7;
   localparam logic [7:0] MASK_REF_GAIN  = 8'h9F;
   localparam logic [7:0] MASK_BANDGAP   = 8'h01;
   localparam logic [7:0] REG_RESET      = 8'h00;

   // Conversion timing in converter clock periods
   localparam logic [4:0] SAMPLE_PERIODS  = 5'h04;
   localparam logic [4:0] CONVERT_PERIODS = 5'h10;
   localparam int         DIV_WIDTH       = 7;

   // Channels
   localparam logic [3:0] LAST_CHANNEL = 4'hA;

   // Input source codes
   typedef enum logic [3:0] {
      ADCREG_SRC_EXT    = 4'h0,
      ADCREG_SRC_VDD    = 4'h1,
      ADCREG_SRC_VDD2   = 4'h2,
      ADCREG_SRC_VDD4   = 4'h3,
      ADCREG_SRC_EXT2   = 4'h4,
      ADCREG_SRC_VR     = 4'h5,
      ADCREG_SRC_VR2    = 4'h6,
      ADCREG_SRC_VR4    = 4'h7,
      ADCREG_SRC_OPAMP  = 4'h8,
      ADCREG_SRC_GND0   = 4'h9,
      ADCREG_SRC_GND1   = 4'hA,
      ADCREG_SRC_GND2   = 4'hB
   } adcreg_src_t;

   // Analog mux selection handed to the converter core
   typedef enum logic [2:0] {
      ADCREG_MUX_EXT   = 3'h0,
      ADCREG_MUX_VDD   = 3'h1,
      ADCREG_MUX_VR    = 3'h2,
      ADCREG_MUX_OPAMP = 3'h3,
      ADCREG_MUX_GND   = 3'h4
   } adcreg_mux_t;
endpackage
`default_nettype wire

// file: adcreg_conv_if.sv
/*
 * Interface between the register block and the conversion sequencer.
 * Assumes both ends run on the same system clock.
 */
`default_nettype none
interface adcreg_conv_if;
   logic        start;
   logic        enable;
   logic [2:0]  divider;
   logic        busy;
   logic        done;
   logic        sampling;
   logic        ck_tick;
   modport regs (output start, output enable, output divider,
                 input busy, input done, input sampling, input ck_tick);
   modport seq  (input start, input enable, input divider,
                 output busy, output done, output sampling,
                 output ck_tick);
endinterface
`default_nettype wire

// file: adcreg_seq.sv
/*
 * Conversion sequencer: divides the system clock and counts sampling and
 * conversion periods. Assumes start is a one-cycle pulse from the
 * register block.
 */
`default_nettype none
module adcreg_seq
   import adcreg_pkg::*;
(
   // Clock and reset
   input wire logic   clk,
   input wire logic   rst_n,
   // Register side
   adcreg_conv_if.seq cv
);
   typedef enum logic [1:0] {
      ADCREG_IDLE   = 2'b00,
      ADCREG_SAMPLE = 2'b01,
      ADCREG_CONV   = 2'b11
   } adcreg_state_t;

   adcreg_state_t          state_q;
   logic [DIV_WIDTH-1:0]   div_q;
   logic [4:0]             per_q;
   logic                   tick;

   function automatic logic div_tick(input logic [DIV_WIDTH-1:0] cnt,
                                     input logic [2:0] code);
      logic [DIV_WIDTH-1:0] lim;
      lim = DIV_WIDTH'((8'h01 << code) - 8'h01);
      return cnt == lim;
   endfunction

   // Divider by two to the code value; restarts with each conversion
   assign tick = div_tick(div_q, cv.divider);

   always_ff @(posedge clk) begin
      if (!rst_n || state_q == ADCREG_IDLE || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // 4 sampling then 12 conversion periods, 16 in all
   always_ff @(posedge clk) begin
      if (!rst_n || !cv.enable) begin
         state_q <= ADCREG_IDLE;
         per_q   <= '0;
      end else begin
         unique case (state_q)
            ADCREG_IDLE: begin
               per_q <= '0;
               if (cv.start) begin
                  state_q <= ADCREG_SAMPLE;
               end
            end
            ADCREG_SAMPLE: begin
               if (tick) begin
                  per_q <= per_q + 1'b1;
                  if (per_q + 1'b1 == SAMPLE_PERIODS) begin
                     state_q <= ADCREG_CONV;
                  end
               end
            end
            ADCREG_CONV: begin
               if (tick) begin
                  per_q <= per_q + 1'b1;
                  if (per_q + 1'b1 == CONVERT_PERIODS) begin
                     state_q <= ADCREG_IDLE;
                  end
               end
            end
            default: begin
               state_q <= ADCREG_IDLE;
            end
         endcase
      end
   end

   assign cv.busy     = state_q != ADCREG_IDLE;
   assign cv.sampling = state_q == ADCREG_SAMPLE;
   assign cv.ck_tick  = tick && state_q != ADCREG_IDLE;
   assign cv.done     = cv.enable && state_q == ADCREG_CONV && tick
                        && per_q + 1'b1 == CONVERT_PERIODS;
endmodule
`default_nettype wire

// file: adcreg_top.sv
/*
 * A/D converter control block: Avalon-MM register slave, result
 * formatting, input and reference selection decode, bandgap and gain
 * amplifier control. Assumes the analog core returns a 12-bit result
 * valid when the sequencer signals done, and an external interrupt
 * controller latches the completion request.
 */
// The register offsets and the Avalon-MM slave port were decided locally.
`default_nettype none
module adcreg_top
   import adcreg_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [1:0]  avs_response,
   // Analog converter core
   input  wire logic [11:0] conv_result,
   output logic             converter_enable,
   output logic             conv_sampling,
   output logic             conv_clock_tick,
   output logic      [2:0]  analog_mux_select,
   output logic      [1:0]  analog_mux_scale,
   output logic      [3:0]  external_channel_select,
   output logic             external_channel_connect,
   output logic      [10:0] analog_pin_claim,
   // Reference and amplifier
   output logic             gain_amp_enable,
   output logic             gain_amp_input_select,
   output logic             ext_amp_input_pin_connect,
   output logic      [1:0]  gain_amp_gain_select,
   output logic      [1:0]  reference_source_select,
   output logic             ext_ref_pin_connect,
   output logic             bandgap_enable,
   output logic             bandgap_force_low,
   // Interrupt request
   output logic             conversion_done_irq
);
   adcreg_conv_if cv ();

   logic [7:0]  start_format_channel_q;
   logic [7:0]  source_clock_q;
   logic [7:0]  reference_gain_q;
   logic [7:0]  bandgap_ctrl_q;
   logic [7:0]  result_high_byte_q;
   logic [7:0]  result_low_byte_q;
   logic        start_armed_q;
   logic        ack_q;
   logic [31:0] readdata_q;
   logic        err_q;
   logic        wr_go;
   logic        rd_go;
   logic        start_pulse;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        hit;
   adcreg_src_t src;

   // One wait state; a write lands only at the edge where waitrequest is
   // low, so a held request is never applied before it is accepted
   assign wr_go = avs_write && ack_q;
   assign rd_go = avs_read && !ack_q;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign wdata = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] nw,
                                        input logic [7:0] mask,
                                        input logic       lane);
      return lane ? (nw & mask) : old;
   endfunction

   function automatic logic is_internal(input adcreg_src_t s);
      return !(s == ADCREG_SRC_EXT || s == ADCREG_SRC_EXT2
               || s[3:2] == 2'b11);
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   // Control registers; busy bit is kept out of storage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         start_format_channel_q <= REG_RESET;
         source_clock_q         <= REG_RESET;
         reference_gain_q       <= REG_RESET;
         bandgap_ctrl_q         <= REG_RESET;
      end else if (wr_go) begin
         unique case (avs_address)
            ADDR_START_FMT: start_format_channel_q <=
               merge(start_format_channel_q, wdata, MASK_START_FMT,
                     avs_byteenable[0]);
            ADDR_SRC_CLK: source_clock_q <=
               merge(source_clock_q, wdata, MASK_SRC_CLK,
                     avs_byteenable[0]);
            ADDR_REF_GAIN: reference_gain_q <=
               merge(reference_gain_q, wdata, MASK_REF_GAIN,
                     avs_byteenable[0]);
            ADDR_BANDGAP: bandgap_ctrl_q <=
               merge(bandgap_ctrl_q, wdata, MASK_BANDGAP,
                     avs_byteenable[0]);
            default: begin
            end
         endcase
      end
   end

   // A high write arms; the following low write fires the conversion
   assign start_pulse = start_armed_q
                        && !start_format_channel_q[BIT_START];
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         start_armed_q <= 1'b0;
      end else if (start_format_channel_q[BIT_START]) begin
         start_armed_q <= 1'b1;
      end else begin
         start_armed_q <= 1'b0;
      end
   end

   assign cv.start   = start_pulse;
   assign cv.enable  = start_format_channel_q[BIT_ENABLE];
   assign cv.divider = source_clock_q[DIV_MSB:0];

   adcreg_seq u_seq (
      .clk   (clk),
      .rst_n (rst_n),
      .cv    (cv.seq)
   );

   // Results load only on completion, both bytes in one edge; a disabled
   // converter never completes, so the old result is kept
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result_high_byte_q <= REG_RESET;
         result_low_byte_q  <= REG_RESET;
      end else if (cv.done) begin
         if (start_format_channel_q[BIT_FORMAT]) begin
            result_high_byte_q <= {4'h0, conv_result[11:8]};
            result_low_byte_q  <= conv_result[7:0];
         end else begin
            result_high_byte_q <= conv_result[11:4];
            result_low_byte_q  <= {conv_result[3:0], 4'h0};
         end
      end
   end

   always_comb begin
      hit   = 1'b1;
      rdata = 8'h00;
      unique case (avs_address)
         ADDR_RESULT_HIGH: rdata = result_high_byte_q;
         ADDR_RESULT_LOW:  rdata = result_low_byte_q;
         ADDR_START_FMT: begin
            rdata = start_format_channel_q;
            rdata[BIT_BUSY] = cv.busy;
         end
         ADDR_SRC_CLK:     rdata = source_clock_q;
         ADDR_REF_GAIN:    rdata = reference_gain_q;
         ADDR_BANDGAP:     rdata = bandgap_ctrl_q;
         default:          hit = 1'b0;
      endcase
   end

   // Unmapped addresses read zero with a slave-error response
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readdata_q <= 32'h0000_0000;
         err_q      <= 1'b0;
      end else if (rd_go || wr_go) begin
         readdata_q <= rd_go ? {24'h00_0000, rdata} : 32'h0000_0000;
         err_q      <= !hit;
      end
   end
   assign avs_readdata = readdata_q;
   assign avs_response = err_q ? 2'b10 : 2'b00;

   // Analog routing decode
   assign src = adcreg_src_t'(source_clock_q[SRC_MSB:SRC_LSB]);
   always_comb begin
      analog_mux_scale = 2'b00;
      unique case (src)
         ADCREG_SRC_VDD, ADCREG_SRC_VDD2, ADCREG_SRC_VDD4: begin
            analog_mux_select = ADCREG_MUX_VDD;
            analog_mux_scale  = 2'(src - ADCREG_SRC_VDD);
         end
         ADCREG_SRC_VR, ADCREG_SRC_VR2, ADCREG_SRC_VR4: begin
            analog_mux_select = ADCREG_MUX_VR;
            analog_mux_scale  = 2'(src - ADCREG_SRC_VR);
         end
         ADCREG_SRC_OPAMP: analog_mux_select = ADCREG_MUX_OPAMP;
         ADCREG_SRC_GND0, ADCREG_SRC_GND1, ADCREG_SRC_GND2:
            analog_mux_select = ADCREG_MUX_GND;
         default: analog_mux_select = ADCREG_MUX_EXT;
      endcase
   end

   assign external_channel_select = start_format_channel_q[CH_MSB:0];
   // Codes past the last channel connect nothing, leaving the input open
   assign external_channel_connect = converter_enable && !is_internal(src)
        && external_channel_select <= LAST_CHANNEL;
   // Claimed pins drop digital function and pull-high in the pad ring
   always_comb begin
      analog_pin_claim = 11'h000;
      if (external_channel_connect) begin
         analog_pin_claim[external_channel_select] = 1'b1;
      end
   end

   assign converter_enable = cv.enable;
   assign conv_sampling    = cv.sampling;
   assign conv_clock_tick  = cv.ck_tick;

   // Amplifier enable is software's duty; the block only passes it on
   assign gain_amp_enable = reference_gain_q[BIT_AMP_EN];
   assign gain_amp_input_select = reference_gain_q[BIT_AMP_IN];
   assign ext_amp_input_pin_connect =
      !reference_gain_q[BIT_AMP_IN];
   assign gain_amp_gain_select = reference_gain_q[GAIN_MSB:0];
   assign reference_source_select =
      reference_gain_q[REF_MSB:REF_LSB];
   assign ext_ref_pin_connect =
      reference_gain_q[REF_MSB:REF_LSB] == 2'b01;
   assign bandgap_enable    = bandgap_ctrl_q[BIT_BG_EN];
   assign bandgap_force_low = !bandgap_ctrl_q[BIT_BG_EN];

   assign conversion_done_irq = cv.done;
endmodule
`default_nettype wire

// file: adcreg_checker.sv
/*
 * Concurrent checks on the ports of adcreg_top.
 * Assumes a single clock domain and a synchronous active-low reset.
 */
`default_nettype none
module adcreg_checker
   import adcreg_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Register bus
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   // Input routing
   input wire logic        converter_enable,
   input wire logic        conv_sampling,
   input wire logic        conv_clock_tick,
   input wire logic [2:0]  analog_mux_select,
   input wire logic [3:0]  external_channel_select,
   input wire logic        external_channel_connect,
   input wire logic [10:0] analog_pin_claim,
   // Reference and bandgap
   input wire logic        gain_amp_input_select,
   input wire logic        ext_amp_input_pin_connect,
   input wire logic [1:0]  reference_source_select,
   input wire logic        ext_ref_pin_connect,
   input wire logic        bandgap_enable,
   input wire logic        bandgap_force_low,
   input wire logic        conversion_done_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence req_pending;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence ack_given;
      !avs_waitrequest;
   endsequence
   sequence irq_single;
      conversion_done_irq ##1 !conversion_done_irq;
   endsequence

   bus_answer_a: assert property (req_pending |=> ack_given)
      else $error("bus request not answered in one cycle");
   idle_ready_a: assert property (!(avs_read || avs_write) |-> ack_given)
      else $error("waitrequest high with no request");
   ext_connect_a: assert property (external_channel_connect ==
      (converter_enable && analog_mux_select == ADCREG_MUX_EXT
       && external_channel_select <= LAST_CHANNEL))
      else $error("external channel connect wrong");
   pin_claim_a: assert property (analog_pin_claim ==
      (external_channel_connect ? 11'h001 << external_channel_select
                                : 11'h000))
      else $error("pin claim wrong");
   amp_pin_a: assert property (ext_amp_input_pin_connect ==
      !gain_amp_input_select)
      else $error("amplifier input pin connect wrong");
   ref_pin_a: assert property (ext_ref_pin_connect ==
      (reference_source_select == 2'h1))
      else $error("reference pin connect wrong");
   bg_low_a: assert property (bandgap_force_low == !bandgap_enable)
      else $error("bandgap force low wrong");
   irq_pulse_a: assert property (conversion_done_irq |-> irq_single)
      else $error("completion request not a single pulse");

   // Counts converter clock periods spent sampling; an abort by disable
   // is left out of the check below
   logic [4:0] smp_ticks_q;
   always_ff @(posedge clk) begin
      if (!rst_n || !conv_sampling) begin
         smp_ticks_q <= 5'h00;
      end else if (conv_clock_tick) begin
         smp_ticks_q <= smp_ticks_q + 5'h01;
      end
   end

   sequence sample_closed;
      $fell(conv_sampling) && converter_enable;
   endsequence

   sample_len_a: assert property (sample_closed |->
      smp_ticks_q == SAMPLE_PERIODS)
      else $error("sampling phase length wrong");
   done_tick_a: assert property (conversion_done_irq |->
      converter_enable && !conv_sampling && conv_clock_tick)
      else $error("completion outside a converting period");
endmodule
`default_nettype wire

// file: adcreg_top_tb.sv
/*
 * Self-checking testbench for adcreg_top over its Avalon-MM slave.
 * Assumes the package and checker are compiled before this file.
 */
`default_nettype none
module adcreg_top_tb
   import adcreg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk            = 1'b0;
   logic        rst_n          = 1'b0;
   logic [4:0]  avs_address    = 5'h00;
   logic        avs_read       = 1'b0;
   logic        avs_write      = 1'b0;
   logic [31:0] avs_writedata  = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [11:0] conv_result    = 12'h000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [1:0]  avs_response;
   logic [2:0]  mux;
   logic [1:0]  scale;
   logic        ch_on;
   logic [1:0]  ref_sel;
   logic [1:0]  gain_sel;
   logic        ref_pin;
   logic        amp_pin;
   logic        bg_en;
   logic        amp_en;
   logic        irq;
   logic [31:0] rd;
   logic [1:0]  resp;
   logic [7:0]  expv [0:5] = '{8'h00, 8'h00, 8'h3F, 8'hF7, 8'h9F, 8'h01};
   int          errors     = 0;
   int          n_compared = 0;
   int          cyc        = 0;
   int          n_irq      = 0;
   int          dt;

   adcreg_top uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .conv_result(conv_result),
      .converter_enable(), .conv_sampling(), .conv_clock_tick(),
      .analog_mux_select(mux), .analog_mux_scale(scale),
      .external_channel_select(), .external_channel_connect(ch_on),
      .analog_pin_claim(), .gain_amp_enable(amp_en),
      .gain_amp_input_select(),
      .ext_amp_input_pin_connect(amp_pin), .gain_amp_gain_select(gain_sel),
      .reference_source_select(ref_sel), .ext_ref_pin_connect(ref_pin),
      .bandgap_enable(bg_en), .bandgap_force_low(),
      .conversion_done_irq(irq));

   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // Completion pulses, one per finished conversion
   always @(posedge clk) if (irq === 1'b1) n_irq <= n_irq + 1;

   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // Request is held until waitrequest is sampled low
   task bus_wr(input logic [4:0] a, input logic [7:0] d);
      avs_address   <= a;
      avs_writedata <= {24'h000000, d};
      avs_write     <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task bus_rd(input logic [4:0] a);
      avs_address <= a;
      avs_read    <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd   = avs_readdata;
      resp = avs_response;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task start_conv(input logic [7:0] base);
      bus_wr(ADDR_START_FMT, base | 8'h80);
      bus_wr(ADDR_START_FMT, base);
   endtask

   task wait_idle;
      int t0;
      t0 = cyc;
      do bus_rd(ADDR_START_FMT);
      while (rd[BIT_BUSY] !== 1'b0 && cyc - t0 < 9000);
      dt = cyc - t0;
   endtask

   function automatic logic [2:0] exp_mux(input logic [3:0] s);
      case (s)
         4'h1, 4'h2, 4'h3: return ADCREG_MUX_VDD;
         4'h5, 4'h6, 4'h7: return ADCREG_MUX_VR;
         4'h8:             return ADCREG_MUX_OPAMP;
         4'h9, 4'hA, 4'hB: return ADCREG_MUX_GND;
         default:          return ADCREG_MUX_EXT;
      endcase
   endfunction

   task close_out;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         bus_rd(5'(i * 4));
         chk(rd[7:0], 8'h00);
         chk(8'(resp), 8'h00);
      end
      bus_rd(5'h18);
      chk(rd[7:0], 8'h00);
      chk(8'(resp), 8'h02);
      $display("test reset and unmapped done");
      bus_wr(ADDR_START_FMT, 8'h7F);
      for (int i = 3; i < 6; i++) bus_wr(5'(i * 4), 8'hFF);
      avs_byteenable <= 4'hE;
      bus_wr(ADDR_BANDGAP, 8'h00);
      avs_byteenable <= 4'hF;
      for (int i = 2; i < 6; i++) begin
         bus_rd(5'(i * 4));
         chk(rd[7:0], expv[i]);
         bus_wr(5'(i * 4), 8'h00);
      end
      $display("test masks done");
      bus_wr(ADDR_START_FMT, 8'h25);
      for (int s = 0; s < 16; s++) begin
         bus_wr(ADDR_SRC_CLK, {4'(s), 4'h0});
         chk(8'(mux), 8'(exp_mux(4'(s))));
         chk(8'(ch_on), 8'(exp_mux(4'(s)) == ADCREG_MUX_EXT));
         if (s % 4 != 0 && s < 8) chk(8'(scale), 8'(s % 4 - 1));
      end
      bus_wr(ADDR_SRC_CLK, 8'h00);
      for (int c = 0; c < 16; c++) begin
         bus_wr(ADDR_START_FMT, 8'h20 | 8'(c));
         chk(8'(ch_on), 8'(c <= 10));
      end
      for (int g = 0; g < 4; g++) begin
         // Bandgap stays on until the amplifier input has left it
         bus_wr(ADDR_BANDGAP, 8'h01);
         bus_wr(ADDR_REF_GAIN,
                {1'b1, 2'b00, g[0], 2'(g), 2'(g)});
         bus_wr(ADDR_BANDGAP, 8'(g % 2));
         chk(8'(gain_sel), 8'(g));
         chk(8'(ref_sel), 8'(g));
         chk(8'(ref_pin), 8'(g == 1));
         chk(8'(amp_pin), 8'(g[0] == 1'b0));
         chk(8'(bg_en), 8'(g % 2));
         chk(8'(amp_en), 8'h01);
      end
      $display("test routing done");
      conv_result <= 12'hABC;
      bus_wr(ADDR_START_FMT, 8'hA0);
      bus_rd(ADDR_START_FMT);
      chk(rd[7:0], 8'hA0);
      bus_wr(ADDR_START_FMT, 8'h20);
      bus_rd(ADDR_START_FMT);
      chk(8'(rd[BIT_BUSY]), 8'h01);
      wait_idle();
      bus_rd(ADDR_RESULT_HIGH);
      chk(rd[7:0], 8'hAB);
      bus_rd(ADDR_RESULT_LOW);
      chk(rd[7:0], 8'hC0);
      conv_result <= 12'h5E7;
      start_conv(8'h30);
      wait_idle();
      bus_rd(ADDR_RESULT_HIGH);
      chk(rd[7:0], 8'h05);
      bus_rd(ADDR_RESULT_LOW);
      chk(rd[7:0], 8'hE7);
      $display("test formats done");
      conv_result <= 12'h123;
      start_conv(8'h20);
      bus_wr(ADDR_START_FMT, 8'h00);
      repeat (40) @(posedge clk);
      bus_rd(ADDR_START_FMT);
      chk(rd[7:0], 8'h00);
      bus_rd(ADDR_RESULT_LOW);
      chk(rd[7:0], 8'hE7);
      $display("test disable done");
      for (int d = 0; d < 8; d++) begin
         bus_wr(ADDR_SRC_CLK, 8'(d));
         start_conv(8'h20);
         wait_idle();
         // Slack covers poll spacing and divider phase
         chk(8'(dt >= (16 << d) - 4 && dt <= (16 << d) + 12 + (1 << d)),
             8'h01);
      end
      chk(8'(n_irq), 8'h0A);
      $display("test conversion timing done");
      close_out();
   end

   initial begin
      #400000;
      errors++;
      close_out();
   end
endmodule

bind adcreg_top adcreg_checker chk_i (.clk(clk), .rst_n(rst_n),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .converter_enable(converter_enable),
   .conv_sampling(conv_sampling), .conv_clock_tick(conv_clock_tick),
   .analog_mux_select(analog_mux_select),
   .external_channel_select(external_channel_select),
   .external_channel_connect(external_channel_connect),
   .analog_pin_claim(analog_pin_claim),
   .gain_amp_input_select(gain_amp_input_select),
   .ext_amp_input_pin_connect(ext_amp_input_pin_connect),
   .reference_source_select(reference_source_select),
   .ext_ref_pin_connect(ext_ref_pin_connect),
   .bandgap_enable(bandgap_enable), .bandgap_force_low(bandgap_force_low),
   .conversion_done_irq(conversion_done_irq));
`default_nettype wire
